// ==== dcr_regs.v ====
// Control and status registers one to five of the line interface: test loops, paths, ring and hook.
//
// Summary of operation
// - Writing one to control one bit 7 resets all registers; bit self-clears.
// - Control one bit 1 enables sample loopback across the isolation barrier.
// - Control two bit 3 selects external analog loopback toward the line.
// - Control two bit 1 connects the hybrid into the transmit path.
// - Control two bit 0 enables the receive path.
// - Register five bit 6 reads one while a negative ring is present.
// - Register five bit 5 reads one while a positive ring is present.
// - Register five bit 3 enables low-power on-hook monitoring for caller identification.
// - Ring indication bit 2 sets on ring; clears after hold time or off-hook.
// - Off-hook request is bit 0 ORed with the off-hook pin when gated.
// - With mode set, on-hook skips the hold-off counter; immediate return allowed.
// - Clearing the hybrid bit selects the internal analog loopback test.
`include "dcr_defines.vh"

module dcr_regs #(
   parameter RING_HOLD_CYC = `DCR_RING_HOLD_CYC,
   parameter HOOK_HOLDOFF_CYC = `DCR_HOOK_HOLDOFF_CYC
) (
   input wire clk_i,
   input wire rst_b_i,
   input wire wr_en_i,
   input wire rd_en_i,
   input wire [`DCR_ADDR_W-1:0] addr_i,
   input wire [7:0] wdata_i,
   output reg [7:0] rdata_o,
   input wire ring_pos_i,
   input wire ring_neg_i,
   input wire offhook_pin_i,
   input wire offhook_pin_gate_i,
   input wire mode_i,
   output reg barrier_loop_test_o,
   output reg line_echo_test_o,
   output reg hybrid_connect_o,
   output reg internal_loop_test_o,
   output reg receive_path_on_o,
   output reg caller_id_listen_o,
   output reg line_seize_o
);
   reg barrier_loop_ff;
   reg line_echo_ff;
   reg hybrid_ff;
   reg rx_on_ff;
   reg cid_listen_ff;
   reg seize_bit_ff;
   reg ring_neg_ff;
   reg ring_pos_ff;
   reg ring_ind_ff;
   reg [31:0] ring_cnt_ff;
   reg [15:0] holdoff_cnt_ff;
   reg seize_req_ff;
   reg [7:0] nxt_rdata;
   reg nxt_seize;
   wire [2:0] pins_sync;
   wire ring_pos_s;
   wire ring_neg_s;
   wire hook_pin_s;
   wire soft_reset;
   wire seize_req;

   // Reset images of the registers, kept as bytes so each field is picked by position, not shifted and truncated.
   localparam [7:0] RST_CTRL1 = `DCR_RST_CTRL1;
   localparam [7:0] RST_CTRL2 = `DCR_RST_CTRL2;
   localparam [7:0] RST_HOOK = `DCR_RST_HOOK;

   // Ring detectors and the hook pin come from outside the clock domain.
   dcr_sync #(.WIDTH(3)) u_sync (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .async_i({offhook_pin_i, ring_neg_i, ring_pos_i}),
      .sync_o(pins_sync)
   );
   assign ring_pos_s = pins_sync[0];
   assign ring_neg_s = pins_sync[1];
   assign hook_pin_s = pins_sync[2];

   // The reset bit is never stored, so it always reads back as zero.
   assign soft_reset = wr_en_i && (addr_i == `DCR_OFS_CTRL1) && wdata_i[`DCR_BIT_SOFT_RESET];

   // Writable control bits; a soft reset takes precedence over any other update.
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         barrier_loop_ff <= RST_CTRL1[`DCR_BIT_BARRIER_LOOP];
         line_echo_ff <= RST_CTRL2[`DCR_BIT_LINE_ECHO];
         hybrid_ff <= RST_CTRL2[`DCR_BIT_HYBRID];
         rx_on_ff <= RST_CTRL2[`DCR_BIT_RX_ON];
         cid_listen_ff <= RST_HOOK[`DCR_BIT_CID_LISTEN];
         seize_bit_ff <= RST_HOOK[`DCR_BIT_SEIZE];
      end else if (soft_reset) begin
         barrier_loop_ff <= RST_CTRL1[`DCR_BIT_BARRIER_LOOP];
         line_echo_ff <= RST_CTRL2[`DCR_BIT_LINE_ECHO];
         hybrid_ff <= RST_CTRL2[`DCR_BIT_HYBRID];
         rx_on_ff <= RST_CTRL2[`DCR_BIT_RX_ON];
         cid_listen_ff <= RST_HOOK[`DCR_BIT_CID_LISTEN];
         seize_bit_ff <= RST_HOOK[`DCR_BIT_SEIZE];
      end else if (wr_en_i) begin
         case (addr_i)
            `DCR_OFS_CTRL1: begin
               barrier_loop_ff <= wdata_i[`DCR_BIT_BARRIER_LOOP];
            end
            `DCR_OFS_CTRL2: begin
               line_echo_ff <= wdata_i[`DCR_BIT_LINE_ECHO];
               hybrid_ff <= wdata_i[`DCR_BIT_HYBRID];
               rx_on_ff <= wdata_i[`DCR_BIT_RX_ON];
            end
            `DCR_OFS_HOOK: begin
               // Only the writable bits are taken; ring bits in the data are dropped.
               cid_listen_ff <= wdata_i[`DCR_BIT_CID_LISTEN];
               seize_bit_ff <= wdata_i[`DCR_BIT_SEIZE];
            end
            default: begin
               barrier_loop_ff <= barrier_loop_ff;
            end
         endcase
      end
   end

   // Effective off-hook request: register bit ORed with the gated pin.
   assign seize_req = seize_bit_ff | (hook_pin_s & offhook_pin_gate_i);

   // Hold-off counter after going on-hook; skipped when mode is set.
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         seize_req_ff <= 1'b0;
         holdoff_cnt_ff <= 16'h0000;
      end else begin
         seize_req_ff <= seize_req;
         if (soft_reset) begin
            holdoff_cnt_ff <= 16'h0000;
         end else if (seize_req_ff && !seize_req && !mode_i) begin
            holdoff_cnt_ff <= HOOK_HOLDOFF_CYC[15:0];
         end else if (seize_req_ff && !seize_req && mode_i) begin
            holdoff_cnt_ff <= 16'h0000;
         end else if (holdoff_cnt_ff != 16'h0000) begin
            holdoff_cnt_ff <= holdoff_cnt_ff - 16'h0001;
         end
      end
   end

   // A new seize waits out the hold-off; releasing the line is always immediate.
   always @* begin
      nxt_seize = seize_req && (line_seize_o || holdoff_cnt_ff == 16'h0000);
   end

   // Ring flags follow the synchronised detectors; ring indication holds after the last positive ring.
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ring_neg_ff <= 1'b0;
         ring_pos_ff <= 1'b0;
         ring_ind_ff <= 1'b0;
         ring_cnt_ff <= 32'h00000000;
      end else begin
         ring_neg_ff <= ring_neg_s;
         ring_pos_ff <= ring_pos_s;
         if (soft_reset || line_seize_o) begin
            ring_ind_ff <= 1'b0;
            ring_cnt_ff <= 32'h00000000;
         end else if (ring_pos_s || ring_neg_s) begin
            ring_ind_ff <= 1'b1;
            if (ring_pos_s) begin
               ring_cnt_ff <= RING_HOLD_CYC[31:0];
            end
         end else if (ring_cnt_ff > 32'h00000001) begin
            ring_cnt_ff <= ring_cnt_ff - 32'h00000001;
         end else begin
            // The hold is loaded by positive rings only and does not count down while a negative ring is present.
            ring_cnt_ff <= 32'h00000000;
            ring_ind_ff <= 1'b0;
         end
      end
   end

   // Read multiplexer; reserved bits and unmapped addresses read zero.
   always @* begin
      nxt_rdata = 8'h00;
      case (addr_i)
         `DCR_OFS_CTRL1: begin
            nxt_rdata[`DCR_BIT_BARRIER_LOOP] = barrier_loop_ff;
         end
         `DCR_OFS_CTRL2: begin
            nxt_rdata[`DCR_BIT_LINE_ECHO] = line_echo_ff;
            nxt_rdata[`DCR_BIT_HYBRID] = hybrid_ff;
            nxt_rdata[`DCR_BIT_RX_ON] = rx_on_ff;
         end
         `DCR_OFS_HOOK: begin
            nxt_rdata[`DCR_BIT_RING_NEG] = ring_neg_ff;
            nxt_rdata[`DCR_BIT_RING_POS] = ring_pos_ff;
            nxt_rdata[`DCR_BIT_CID_LISTEN] = cid_listen_ff;
            nxt_rdata[`DCR_BIT_RING_IND] = ring_ind_ff;
            nxt_rdata[`DCR_BIT_SEIZE] = seize_bit_ff;
         end
         default: begin
            nxt_rdata = 8'h00;
         end
      endcase
   end

   // All outputs are registered; rdata_o loads from the read multiplexer only on a read.
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_o <= 8'h00;
         barrier_loop_test_o <= 1'b0;
         line_echo_test_o <= 1'b0;
         hybrid_connect_o <= 1'b0;
         internal_loop_test_o <= 1'b0;
         receive_path_on_o <= 1'b0;
         caller_id_listen_o <= 1'b0;
         line_seize_o <= 1'b0;
      end else begin
         if (rd_en_i) begin
            rdata_o <= nxt_rdata;
         end
         barrier_loop_test_o <= barrier_loop_ff;
         line_echo_test_o <= line_echo_ff;
         hybrid_connect_o <= hybrid_ff;
         internal_loop_test_o <= ~hybrid_ff;
         receive_path_on_o <= rx_on_ff;
         caller_id_listen_o <= cid_listen_ff;
         line_seize_o <= nxt_seize & ~soft_reset;
      end
   end
endmodule

// ==== dcr_defines.vh ====
// Offsets, bit positions, reset values and timing constants of the line control register bank.
`ifndef DCR_DEFINES_VH
`define DCR_DEFINES_VH

`define DCR_ADDR_W 8
`define DCR_OFS_CTRL1 8'h01
`define DCR_OFS_CTRL2 8'h02
`define DCR_OFS_RSVD3 8'h03
`define DCR_OFS_RSVD4 8'h04
`define DCR_OFS_HOOK 8'h05

`define DCR_BIT_SOFT_RESET 7
`define DCR_BIT_BARRIER_LOOP 1
`define DCR_BIT_LINE_ECHO 3
`define DCR_BIT_HYBRID 1
`define DCR_BIT_RX_ON 0
`define DCR_BIT_RING_NEG 6
`define DCR_BIT_RING_POS 5
`define DCR_BIT_CID_LISTEN 3
`define DCR_BIT_RING_IND 2
`define DCR_BIT_SEIZE 0

`define DCR_RST_CTRL1 8'h00
`define DCR_RST_CTRL2 8'h00
`define DCR_RST_HOOK 8'h00

`define DCR_CLK_MHZ 100
`define DCR_RING_HOLD_MS 4500
`define DCR_RING_HOLD_CYC (`DCR_RING_HOLD_MS * 1000 * `DCR_CLK_MHZ)
`define DCR_HOOK_HOLDOFF_CYC 16

`endif

// ==== dcr_sync.v ====
// Two flip-flop synchroniser for a group of asynchronous level inputs.
module dcr_sync #(
   parameter WIDTH = 1
) (
   input wire clk_i,
   input wire rst_b_i,
   input wire [WIDTH-1:0] async_i,
   output wire [WIDTH-1:0] sync_o
);
   reg [WIDTH-1:0] meta_ff;
   reg [WIDTH-1:0] sync_ff;

   // The first stage feeds only the second stage to contain metastability.
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta_ff <= {WIDTH{1'b0}};
         sync_ff <= {WIDTH{1'b0}};
      end else begin
         meta_ff <= async_i;
         sync_ff <= meta_ff;
      end
   end

   assign sync_o = sync_ff;
endmodule

// ==== dcr_regs_asserts.sv ====
// Concurrent checks on the ports of the line control register bank.
module dcr_regs_asserts #(
   parameter HOOK_HOLDOFF_CYC = 16
) (
   input wire clk_i,
   input wire rst_b_i,
   input wire wr_en_i,
   input wire rd_en_i,
   input wire [7:0] addr_i,
   input wire [7:0] wdata_i,
   input wire [7:0] rdata_o,
   input wire offhook_pin_gate_i,
   input wire mode_i,
   input wire barrier_loop_test_o,
   input wire line_echo_test_o,
   input wire hybrid_connect_o,
   input wire internal_loop_test_o,
   input wire receive_path_on_o,
   input wire caller_id_listen_o,
   input wire line_seize_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   // Write strobes decoded per register.
   wire w1 = wr_en_i && addr_i == 8'h01;
   wire w2 = wr_en_i && addr_i == 8'h02;
   wire w5 = wr_en_i && addr_i == 8'h05;
   barrier_write_a: assert property (w1 && !wdata_i[7] |-> ##2 barrier_loop_test_o == $past(wdata_i[1], 2))
      else $error("barrier loop output wrong");
   echo_write_a: assert property (w2 |-> ##2 line_echo_test_o == $past(wdata_i[3], 2))
      else $error("line echo output wrong");
   hybrid_write_a: assert property (w2 |-> ##2 hybrid_connect_o == $past(wdata_i[1], 2))
      else $error("hybrid output wrong");
   rx_write_a: assert property (w2 |-> ##2 receive_path_on_o == $past(wdata_i[0], 2))
      else $error("receive path output wrong");
   cid_write_a: assert property (w5 |-> ##2 caller_id_listen_o == $past(wdata_i[3], 2))
      else $error("listen output wrong");
   soft_reset_a: assert property (w1 && wdata_i[7] |-> ##2 !(barrier_loop_test_o || line_echo_test_o
      || hybrid_connect_o || receive_path_on_o || caller_id_listen_o))
      else $error("soft reset left a bit set");
   internal_loop_a: assert property (rst_b_i && $past(rst_b_i, 2) |-> internal_loop_test_o == !hybrid_connect_o)
      else $error("internal loop not inverse of hybrid");
   rsvd_read_a: assert property (rd_en_i && (addr_i inside {8'h00, 8'h03, 8'h04} || addr_i > 8'h05) |=> rdata_o == 8'h00)
      else $error("reserved read not zero");
   fixed_zero_a: assert property (rd_en_i |=> (rdata_o & ($past(addr_i) == 8'h01 ? 8'hfd :
      $past(addr_i) == 8'h02 ? 8'hf4 : 8'h92)) == 8'h00)
      else $error("reserved bit not zero");
   seize_release_a: assert property (w5 && !wdata_i[0] && !offhook_pin_gate_i ##1 !offhook_pin_gate_i
      |=> !line_seize_o)
      else $error("seize not released");
   // Eight cycles stays inside the sixteen cycle holdoff, so the check never races its end.
   holdoff_a: assert property ($fell(line_seize_o) && !$past(mode_i) && !$past(w1 && wdata_i[7])
      |-> !line_seize_o [*8])
      else $error("seize returned during holdoff");
   cover property (w1 && wdata_i[7]);
   cover property ($fell(line_seize_o) && !$past(mode_i));
   cover property (rd_en_i && addr_i == 8'h05 ##1 rdata_o[2]);
endmodule

// ==== dcr_dsp_model.sv ====
// Behavioural controller that reaches the register bank with write and read strobes.
module dcr_dsp_model (
   input wire clk_i,
   input wire [7:0] rdata_i,
   output logic wr_en_o,
   output logic rd_en_o,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {wr_en_o, rd_en_o, addr_o, wdata_o} = '0;
   // A released bus shows inverted values, so stale data can never pass for a fresh request.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      {wr_en_o, addr_o, wdata_o} = {1'b1, a, d};
      @(negedge clk_i);
      {wr_en_o, addr_o, wdata_o} = {1'b0, ~a, ~d};
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_i);
      {rd_en_o, addr_o} = {1'b1, a};
      @(negedge clk_i);
      {rd_en_o, addr_o} = {1'b0, ~a};
      @(negedge clk_i);
      d = rdata_i;
   endtask
endmodule

// ==== tb_dcr_regs.sv ====
// Self-checking bench for the line control register bank.
module tb_dcr_regs;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, rst_b_i = 0, rp = 0, rn = 0, pin = 0, gate = 0, mode = 0;
   wire wr, rd;
   wire [7:0] addr, wdata, rdata;
   wire [6:0] outs;
   logic [7:0] r;
   int num_errors = 0, checks_done = 0;
   logic [31:0] rows [12];
   dcr_regs #(.RING_HOLD_CYC(50), .HOOK_HOLDOFF_CYC(16)) i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .wr_en_i(wr),
      .rd_en_i(rd), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .ring_pos_i(rp), .ring_neg_i(rn),
      .offhook_pin_i(pin), .offhook_pin_gate_i(gate), .mode_i(mode), .barrier_loop_test_o(outs[6]),
      .line_echo_test_o(outs[5]), .hybrid_connect_o(outs[4]), .internal_loop_test_o(outs[3]),
      .receive_path_on_o(outs[2]), .caller_id_listen_o(outs[1]), .line_seize_o(outs[0]));
   dcr_dsp_model i_dsp (.clk_i(clk_i), .rdata_i(rdata), .wr_en_o(wr), .rd_en_o(rd), .addr_o(addr), .wdata_o(wdata));
   initial forever #5 clk_i = ~clk_i;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      i_dsp.rd(a, r);
      chk(r, e);
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic conclude;
      $display("Mismatches %0d, comparisons %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Rows hold offset, write data, read-back and the seven control outputs; one test mode at a time.
   initial begin
      rows = '{32'h02020210, 32'h01020250, 32'h01000010, 32'h020b0b34, 32'h0201010c, 32'h02f20210,
         32'h05080812, 32'h05610111, 32'h05000010, 32'h03ff0010, 32'h04ff0010, 32'h06ff0010};
      // The line side counts as powered and enabled before the barrier loop row is written.
      wt(12);
      rst_b_i = 1;
      wt(3);
      chk({1'b0, outs}, 8'h08);
      rdc(8'h05, 8'h00);
      foreach (rows[i]) begin
         i_dsp.wr(rows[i][31:24], rows[i][23:16]);
         rdc(rows[i][31:24], rows[i][15:8]);
         chk({1'b0, outs}, {1'b0, rows[i][6:0]});
      end
      // Ring flags, then the indication timing out from the last positive ring.
      rp = 1;
      wt(6);
      rdc(8'h05, 8'h24);
      {rp, rn} = 2'b01;
      wt(6);
      rdc(8'h05, 8'h44);
      rn = 0;
      wt(60);
      rdc(8'h05, 8'h00);
      rp = 1;
      wt(6);
      rp = 0;
      i_dsp.wr(8'h05, 8'h01);
      wt(2);
      rdc(8'h05, 8'h01);
      // Going on-hook with mode clear arms the holdoff; with mode set it does not.
      i_dsp.wr(8'h05, 8'h00);
      i_dsp.wr(8'h05, 8'h01);
      wt(2);
      chk({7'h00, outs[0]}, 8'h00);
      wt(20);
      chk({7'h00, outs[0]}, 8'h01);
      mode = 1;
      i_dsp.wr(8'h05, 8'h00);
      wt(2);
      mode = 0;
      i_dsp.wr(8'h05, 8'h01);
      wt(2);
      chk({7'h00, outs[0]}, 8'h01);
      i_dsp.wr(8'h05, 8'h00);
      wt(20);
      {pin, gate} = 2'b11;
      wt(5);
      chk({7'h00, outs[0]}, 8'h01);
      gate = 0;
      wt(3);
      chk({7'h00, outs[0]}, 8'h00);
      pin = 0;
      i_dsp.wr(8'h02, 8'h0b);
      i_dsp.wr(8'h05, 8'h08);
      i_dsp.wr(8'h01, 8'h80);
      wt(2);
      chk({1'b0, outs}, 8'h08);
      rdc(8'h01, 8'h00);
      rdc(8'h02, 8'h00);
      rdc(8'h05, 8'h00);
      // A mid-run asynchronous reset clears outputs at once; it is held three edges so the checker sees it.
      i_dsp.wr(8'h02, 8'h0b);
      rdc(8'h02, 8'h0b);
      chk({1'b0, outs}, 8'h34);
      rst_b_i = 0;
      #1;
      chk({1'b0, outs}, 8'h00);
      chk(rdata, 8'h00);
      wt(3);
      rst_b_i = 1;
      wt(3);
      chk({1'b0, outs}, 8'h08);
      rdc(8'h02, 8'h00);
      conclude;
   end
   initial begin
      #100us;
      num_errors++;
      conclude;
   end
endmodule
bind dcr_regs dcr_regs_asserts #(.HOOK_HOLDOFF_CYC(HOOK_HOLDOFF_CYC)) i_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
   .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
   .offhook_pin_gate_i(offhook_pin_gate_i), .mode_i(mode_i), .barrier_loop_test_o(barrier_loop_test_o),
   .line_echo_test_o(line_echo_test_o), .hybrid_connect_o(hybrid_connect_o),
   .internal_loop_test_o(internal_loop_test_o), .receive_path_on_o(receive_path_on_o),
   .caller_id_listen_o(caller_id_listen_o), .line_seize_o(line_seize_o));
